// File: rtl/fan_pwm_duty_arbiter_consts.vh
/*
 * Constants for the fan PWM duty arbiter: register offsets,
 * reset values, step sizes and tick timing.
 * Assumes a 100 MHz clock and a plain byte-wide register port.
 */
// Operation
// R1: Hot assert captures others' duty plus one step
// R2: Enabled, hot asserted: add step each interval
// R3: Ramp-up saturates at full duty
// R4: Enabled, hot released: subtract step each interval
// R5: Disable when released and below others' duty
// R6: Capture sequence reruns only after disable
// R7: One ramp per hot input per bound output
// R8: Both hot bindings: take larger ramp
// R9: Throttle over threshold ramps bound outputs up
// R10: New measurement under limit ramps down
// R11: Throttle inputs have own output bindings
// R12: Both throttle bindings: take larger ramp
// R13: Manual override uses software duty, raisable
// R14: Final duty zero to nonzero triggers spin-up (code skips spin-up while manual override is on)
// R15: Spin-up requests programmed duty for programmed time
// R16: Each output duty readable as 8 bits
// R17: Override held low byte then high byte
// R18: Final duty is priority maximum of requests
// R19: Ramp step equals one 4-bit mapping step
// R20: Millisecond tick from clock times ramp interval
`ifndef FAN_PWM_DUTY_ARBITER_CONSTS_VH
`define FAN_PWM_DUTY_ARBITER_CONSTS_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define REG_PWM1_DUTY_READBACK  8'h0A
`define REG_PWM2_DUTY_READBACK  8'h0B
`define REG_PWM1_OVERRIDE_LOW   8'h0C
`define REG_PWM1_OVERRIDE_HIGH  8'h0D
`define REG_PWM2_OVERRIDE_LOW   8'h0E
`define REG_PWM2_OVERRIDE_HIGH  8'h0F
`define REG_RAMP_CONTROL        8'h50
`define REG_HOT_BINDING         8'h51
`define REG_THROTTLE_BINDING    8'h52
`define REG_OVERRIDE_CONTROL    8'h53
`define REG_SPINUP_DUTY         8'h54
`define REG_SPINUP_TIME         8'h55
`define REG_THROTTLE_LIMIT_A    8'h56
`define REG_THROTTLE_LIMIT_B    8'h57
`define REG_RAMP_STATUS         8'h58

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RST_BYTE                8'h00
`define RST_RAMP_CONTROL        8'h01
`define RST_SPINUP_DUTY         8'h0D
`define RST_SPINUP_TIME         8'h02

// ---------------------------------------------------------------
// Duty scale: 8-bit duty, step of 6.25 percent = 16/256
// ---------------------------------------------------------------
`define DUTY_ZERO               8'h00
`define DUTY_FULL               8'hFF
`define DUTY_STEP               8'h10
`define DUTY_FIRST_STEP         8'h40
`define STEP_CODE_MAX           4'hD
`define STEP_CODE_ONE           4'h1

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_FREQ_HZ             100000000
`define TICK_PERIOD_US          1000
`define TICK_CYCLES             ((`CLK_FREQ_HZ / 1000000) * `TICK_PERIOD_US)

`endif

// File: rtl/fan_pwm_duty_arbiter.v
/*
 * Fan PWM duty arbiter for two outputs: regulator-hot ramps, processor
 * throttle ramps, manual override, spin-up control and final maximum.
 * Assumes synchronous inputs, an 8-bit register port with read data one
 * cycle after the strobe, and external full-duty and automatic requests.
 */
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "fan_pwm_duty_arbiter_consts.vh"

module fan_pwm_duty_arbiter #(
	parameter TICK_CYCLES = `TICK_CYCLES
) (
	input  wire       clk_i,
	input  wire       rstn_i,
	input  wire [7:0] addr_i,
	input  wire [7:0] wdata_i,
	input  wire       wr_i,
	input  wire       rd_i,
	output reg  [7:0] rdata_o,
	input  wire       regulator_hot_a_i,
	input  wire       regulator_hot_b_i,
	input  wire [7:0] processor_throttle_a_i,
	input  wire [7:0] processor_throttle_b_i,
	input  wire       throttle_valid_a_i,
	input  wire       throttle_valid_b_i,
	input  wire [1:0] full_duty_req_i,
	input  wire [7:0] auto_duty_pwm1_i,
	input  wire [7:0] auto_duty_pwm2_i,
	output reg  [7:0] pwm1_duty_o,
	output reg  [7:0] pwm2_duty_o
);

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function [7:0] max8;
		input [7:0] a;
		input [7:0] b;
		begin
			max8 = (a > b) ? a : b;
		end
	endfunction

	// Step code 1..13 to 8-bit duty: 25% then 6.25% per step
	function [7:0] step_duty;
		input [3:0] code;
		begin
			if (code == 4'h0)
				step_duty = `DUTY_ZERO;
			else if (code >= `STEP_CODE_MAX)
				step_duty = `DUTY_FULL;
			else
				step_duty = `DUTY_FIRST_STEP + ((code - `STEP_CODE_ONE) * `DUTY_STEP);
		end
	endfunction

	// Raw duty to the step code just at or above it
	function [3:0] duty_code;
		input [7:0] duty;
		reg   [7:0] above;
		begin
			above = duty - `DUTY_FIRST_STEP + `DUTY_STEP - 8'h01;
			if (duty == `DUTY_ZERO)
				duty_code = 4'h0;
			else if (duty <= `DUTY_FIRST_STEP)
				duty_code = `STEP_CODE_ONE;
			else if (duty > `DUTY_FULL - `DUTY_STEP + 8'h01)
				duty_code = `STEP_CODE_MAX;
			else
				duty_code = `STEP_CODE_ONE + above[7:4];
		end
	endfunction

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	reg  [7:0]  ramp_control_reg;
	reg  [7:0]  hot_binding_reg;
	reg  [7:0]  throttle_binding_reg;
	reg  [7:0]  override_control_reg;
	reg  [7:0]  spinup_duty_reg;
	reg  [7:0]  spinup_time_reg;
	reg  [7:0]  throttle_limit_a_reg;
	reg  [7:0]  throttle_limit_b_reg;
	reg  [15:0] override1_reg;
	reg  [15:0] override2_reg;

	always @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			ramp_control_reg     <= `RST_RAMP_CONTROL;
			hot_binding_reg      <= `RST_BYTE;
			throttle_binding_reg <= `RST_BYTE;
			override_control_reg <= `RST_BYTE;
			spinup_duty_reg      <= `RST_SPINUP_DUTY;
			spinup_time_reg      <= `RST_SPINUP_TIME;
			throttle_limit_a_reg <= `RST_BYTE;
			throttle_limit_b_reg <= `RST_BYTE;
			override1_reg        <= {`RST_BYTE, `RST_BYTE};
			override2_reg        <= {`RST_BYTE, `RST_BYTE};
		end
		else if (wr_i)
		begin
			case (addr_i)
				`REG_RAMP_CONTROL:       ramp_control_reg     <= wdata_i;
				`REG_HOT_BINDING:        hot_binding_reg      <= wdata_i;
				`REG_THROTTLE_BINDING:   throttle_binding_reg <= wdata_i;
				`REG_OVERRIDE_CONTROL:   override_control_reg <= wdata_i;
				`REG_SPINUP_DUTY:        spinup_duty_reg      <= wdata_i;
				`REG_SPINUP_TIME:        spinup_time_reg      <= wdata_i;
				`REG_THROTTLE_LIMIT_A:   throttle_limit_a_reg <= wdata_i;
				`REG_THROTTLE_LIMIT_B:   throttle_limit_b_reg <= wdata_i;
				`REG_PWM1_OVERRIDE_LOW:  override1_reg[7:0]   <= wdata_i; // R17
				`REG_PWM1_OVERRIDE_HIGH: override1_reg[15:8]  <= wdata_i; // R17
				`REG_PWM2_OVERRIDE_LOW:  override2_reg[7:0]   <= wdata_i; // R17
				`REG_PWM2_OVERRIDE_HIGH: override2_reg[15:8]  <= wdata_i; // R17
				default:                 ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Ramp interval tick
	// ---------------------------------------------------------------
	reg  [31:0] ms_count_reg;
	reg  [7:0]  interval_count_reg;
	reg         ms_tick_reg;
	reg         ramp_tick_reg;
	wire        ms_end = (ms_count_reg == TICK_CYCLES - 1);

	always @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			ms_count_reg       <= 32'h0000_0000;
			interval_count_reg <= 8'h00;
			ms_tick_reg        <= 1'b0;
			ramp_tick_reg      <= 1'b0;
		end
		else
		begin
			ms_tick_reg   <= ms_end;
			ramp_tick_reg <= 1'b0;
			if (ms_end)
			begin
				ms_count_reg <= 32'h0000_0000;
				// Interval of ramp_control ms, zero treated as one
				if (interval_count_reg + 8'h01 >= ramp_control_reg) // R20
				begin
					interval_count_reg <= 8'h00;
					ramp_tick_reg      <= 1'b1;
				end
				else
					interval_count_reg <= interval_count_reg + 8'h01;
			end
			else
				ms_count_reg <= ms_count_reg + 32'h0000_0001;
		end
	end

	// ---------------------------------------------------------------
	// Throttle over-limit flags, updated only on new measurements
	// ---------------------------------------------------------------
	reg [1:0] throttle_hot_reg;

	always @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			throttle_hot_reg <= 2'b00;
		else
		begin
			if (throttle_valid_a_i)
				throttle_hot_reg[0] <= (processor_throttle_a_i > throttle_limit_a_reg); // R9 R10
			if (throttle_valid_b_i)
				throttle_hot_reg[1] <= (processor_throttle_b_i > throttle_limit_b_reg); // R9 R10
		end
	end

	// ---------------------------------------------------------------
	// Eight ramp instances: index = out*4 + src (hot a, hot b, thr a, thr b)
	// ---------------------------------------------------------------
	wire [3:0]  src_hot = {throttle_hot_reg, regulator_hot_b_i, regulator_hot_a_i};
	wire [7:0]  ramp_bind = {throttle_binding_reg[3:2], hot_binding_reg[3:2],
				throttle_binding_reg[1:0], hot_binding_reg[1:0]}; // R7 R11
	wire [7:0]  other_req [0:1];
	reg  [7:0]  ramp_en_reg;
	reg  [3:0]  ramp_code_reg [0:7];

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1)
		begin : g_ramp
			wire        hot    = src_hot[gi % 4] & ramp_bind[gi];
			wire [7:0]  other  = other_req[gi / 4];
			wire [7:0]  duty   = step_duty(ramp_code_reg[gi]);
			always @(posedge clk_i or negedge rstn_i)
			begin
				if (!rstn_i)
				begin
					ramp_en_reg[gi]   <= 1'b0;
					ramp_code_reg[gi] <= 4'h0;
				end
				else if (!ramp_en_reg[gi])
				begin
					if (hot)
					begin
						ramp_en_reg[gi] <= 1'b1; // R1 R6
						ramp_code_reg[gi] <= (duty_code(other) >= `STEP_CODE_MAX) ?
							`STEP_CODE_MAX : duty_code(other) + `STEP_CODE_ONE; // R1 R19
					end
				end
				else if (!hot && duty < other)
				begin
					ramp_en_reg[gi]   <= 1'b0; // R5
					ramp_code_reg[gi] <= 4'h0;
				end
				else if (ramp_tick_reg)
				begin
					if (hot && ramp_code_reg[gi] < `STEP_CODE_MAX)
						ramp_code_reg[gi] <= ramp_code_reg[gi] + `STEP_CODE_ONE; // R2 R3 R9
					else if (!hot && ramp_code_reg[gi] > 4'h0)
						ramp_code_reg[gi] <= ramp_code_reg[gi] - `STEP_CODE_ONE; // R4 R10
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Per-output combination
	// ---------------------------------------------------------------
	reg  [1:0]  final_zero_reg;
	reg  [1:0]  spin_active_reg;
	reg  [15:0] spin_count_reg [0:1];
	wire [7:0]  final_duty [0:1];
	wire [7:0]  override_duty [0:1];

	assign override_duty[0] = override1_reg[15:8]; // R13
	assign override_duty[1] = override2_reg[15:8]; // R13

	generate
		for (gi = 0; gi < 2; gi = gi + 1)
		begin : g_out
			wire [7:0] auto_in  = (gi == 0) ? auto_duty_pwm1_i : auto_duty_pwm2_i;
			wire       ovr      = override_control_reg[gi];
			wire [7:0] full     = full_duty_req_i[gi] ? `DUTY_FULL : `DUTY_ZERO;
			wire [7:0] hot_max  = max8(ramp_en_reg[gi*4]   ? g_ramp[gi*4].duty   : `DUTY_ZERO,
						   ramp_en_reg[gi*4+1] ? g_ramp[gi*4+1].duty : `DUTY_ZERO); // R8
			wire [7:0] thr_max  = max8(ramp_en_reg[gi*4+2] ? g_ramp[gi*4+2].duty : `DUTY_ZERO,
						   ramp_en_reg[gi*4+3] ? g_ramp[gi*4+3].duty : `DUTY_ZERO); // R12
			// Spin-up duty is held as a 4-bit step code
			wire [7:0] spin     = spin_active_reg[gi] ? step_duty(spinup_duty_reg[3:0]) : `DUTY_ZERO; // R15
			wire [7:0] low_req  = ovr ? override_duty[gi] : max8(spin, auto_in); // R13 R18
			// Captured base excludes the ramps themselves
			assign other_req[gi]  = max8(full, low_req);
			assign final_duty[gi] = max8(max8(full, hot_max), max8(thr_max, low_req)); // R18

			always @(posedge clk_i or negedge rstn_i)
			begin
				if (!rstn_i)
				begin
					final_zero_reg[gi]  <= 1'b1;
					spin_active_reg[gi] <= 1'b0;
					spin_count_reg[gi]  <= 16'h0000;
				end
				else
				begin
					final_zero_reg[gi] <= (final_duty[gi] == `DUTY_ZERO);
					if (final_zero_reg[gi] && final_duty[gi] != `DUTY_ZERO && !ovr)
					begin
						spin_active_reg[gi] <= 1'b1; // R14
						spin_count_reg[gi]  <= {8'h00, spinup_time_reg};
					end
					else if (spin_active_reg[gi] && ramp_tick_reg)
					begin
						if (spin_count_reg[gi] <= 16'h0001)
							spin_active_reg[gi] <= 1'b0; // R15
						spin_count_reg[gi] <= spin_count_reg[gi] - 16'h0001;
					end
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Outputs and read port
	// ---------------------------------------------------------------
	always @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			pwm1_duty_o <= `DUTY_ZERO;
			pwm2_duty_o <= `DUTY_ZERO;
			rdata_o     <= `RST_BYTE;
		end
		else
		begin
			pwm1_duty_o <= final_duty[0];
			pwm2_duty_o <= final_duty[1];
			if (rd_i)
			begin
				case (addr_i)
					`REG_PWM1_DUTY_READBACK: rdata_o <= pwm1_duty_o; // R16
					`REG_PWM2_DUTY_READBACK: rdata_o <= pwm2_duty_o; // R16
					`REG_PWM1_OVERRIDE_LOW:  rdata_o <= override1_reg[7:0];
					`REG_PWM1_OVERRIDE_HIGH: rdata_o <= override1_reg[15:8];
					`REG_PWM2_OVERRIDE_LOW:  rdata_o <= override2_reg[7:0];
					`REG_PWM2_OVERRIDE_HIGH: rdata_o <= override2_reg[15:8];
					`REG_RAMP_CONTROL:       rdata_o <= ramp_control_reg;
					`REG_HOT_BINDING:        rdata_o <= hot_binding_reg;
					`REG_THROTTLE_BINDING:   rdata_o <= throttle_binding_reg;
					`REG_OVERRIDE_CONTROL:   rdata_o <= override_control_reg;
					`REG_SPINUP_DUTY:        rdata_o <= spinup_duty_reg;
					`REG_SPINUP_TIME:        rdata_o <= spinup_time_reg;
					`REG_THROTTLE_LIMIT_A:   rdata_o <= throttle_limit_a_reg;
					`REG_THROTTLE_LIMIT_B:   rdata_o <= throttle_limit_b_reg;
					`REG_RAMP_STATUS:        rdata_o <= ramp_en_reg;
					default:                 rdata_o <= `RST_BYTE;
				endcase
			end
			else
				rdata_o <= `RST_BYTE;
		end
	end

endmodule

// File: verification/fan_pwm_duty_arbiter_assertions.sv
/* Port checker for the fan duty arbiter.
   Bound to the top module; one clock domain. */
`timescale 1ns/1ps
module fan_pwm_duty_arbiter_assertions (
	input wire       clk_i,
	input wire       rstn_i,
	input wire [7:0] addr_i,
	input wire [7:0] wdata_i,
	input wire       wr_i,
	input wire       rd_i,
	input wire [7:0] rdata_o,
	input wire [1:0] full_duty_req_i,
	input wire [7:0] pwm1_duty_o,
	input wire [7:0] pwm2_duty_o
);
default clocking @(posedge clk_i);
endclocking
default disable iff (!rstn_i);
// ----
// Shadow of written registers
// ----
reg [7:0] lo1;
reg       ov1;
always @(posedge clk_i or negedge rstn_i)
	if (!rstn_i)
	begin
		lo1 <= 8'h00;
		ov1 <= 1'b0;
	end
	else if (wr_i)
	begin
		if (addr_i == 8'h0C)
			lo1 <= wdata_i;
		if (addr_i == 8'h53)
			ov1 <= wdata_i[0];
	end
property p_rd_idle;
	!$past(rd_i) |-> rdata_o == 8'h00;
endproperty
a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
property p_rb1;
	rd_i && addr_i == 8'h0A |=> rdata_o == $past(pwm1_duty_o);
endproperty
a_rb1: assert property (p_rb1) else $error("pwm1 readback wrong");
property p_rb2;
	rd_i && addr_i == 8'h0B |=> rdata_o == $past(pwm2_duty_o);
endproperty
a_rb2: assert property (p_rb2) else $error("pwm2 readback wrong");
property p_lo;
	rd_i && addr_i == 8'h0C |=> rdata_o == lo1;
endproperty
a_lo: assert property (p_lo) else $error("override low byte wrong");
property p_full1;
	full_duty_req_i[0] |=> pwm1_duty_o == 8'hFF;
endproperty
a_full1: assert property (p_full1) else $error("pwm1 not full");
property p_full2;
	full_duty_req_i[1] |=> pwm2_duty_o == 8'hFF;
endproperty
a_full2: assert property (p_full2) else $error("pwm2 not full");
property p_spin;
	!ov1 && pwm1_duty_o != 8'h00 && $past(pwm1_duty_o) == 8'h00 |-> ##[0:3] pwm1_duty_o == 8'hFF;
endproperty
a_spin: assert property (p_spin) else $error("no spin-up");
property p_ov;
	wr_i && addr_i == 8'h0D && ov1 |-> ##2 pwm1_duty_o >= $past(wdata_i, 2);
endproperty
a_ov: assert property (p_ov) else $error("override duty not applied");
endmodule
bind fan_pwm_duty_arbiter fan_pwm_duty_arbiter_assertions u_chk (.clk_i(clk_i), .rstn_i(rstn_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.full_duty_req_i(full_duty_req_i), .pwm1_duty_o(pwm1_duty_o), .pwm2_duty_o(pwm2_duty_o));

// File: verification/hot_source_model.sv
/* Regulator-hot and throttle source model.
   Bench commands; outputs change after rising edges. */
`timescale 1ns/1ps
module hot_source_model (
	input  wire       clk_i,
	input  wire       rstn_i,
	input  wire       hot_a_cmd_i,
	input  wire       hot_b_cmd_i,
	input  wire [7:0] meas_i,
	input  wire       meas_go_i,
	output reg        hot_a_o,
	output reg        hot_b_o,
	output reg  [7:0] thr_o,
	output reg        thr_valid_o
);
always @(posedge clk_i or negedge rstn_i)
	if (!rstn_i)
	begin
		hot_a_o <= 1'b0;
		hot_b_o <= 1'b0;
		thr_o <= 8'h00;
		thr_valid_o <= 1'b0;
	end
	else
	begin
		hot_a_o <= hot_a_cmd_i;
		hot_b_o <= hot_b_cmd_i;
		thr_valid_o <= meas_go_i;
		// Stale value is not held between samples
		thr_o <= meas_go_i ? meas_i : ~thr_o;
	end
endmodule

// File: verification/fan_pwm_duty_arbiter_tb.sv
/* Testbench for the fan duty arbiter.
   Uses the source model; short tick of 10 cycles. */
`timescale 1ns/1ps
module fan_pwm_duty_arbiter_tb;
reg        clk_i = 1'b0;
reg        rstn_i = 1'b0;
reg  [7:0] addr_i = 8'h00;
reg  [7:0] wdata_i = 8'h00;
reg        wr_i = 1'b0;
reg        rd_i = 1'b0;
reg        hot_a = 1'b0;
reg  [7:0] meas = 8'h00;
reg        go = 1'b0;
reg  [1:0] full = 2'b00;
reg  [7:0] auto1 = 8'h00;
wire [7:0] rdata_o;
wire [7:0] pwm1;
wire [7:0] pwm2;
wire       vh_a;
wire       vh_b;
wire [7:0] thr;
wire       tv;
integer    errors = 0;
integer    checked = 0;
always #5 clk_i = ~clk_i;
fan_pwm_duty_arbiter #(.TICK_CYCLES(10)) u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .regulator_hot_a_i(vh_a),
	.regulator_hot_b_i(vh_b), .processor_throttle_a_i(thr), .processor_throttle_b_i(8'h00),
	.throttle_valid_a_i(tv), .throttle_valid_b_i(1'b0), .full_duty_req_i(full),
	.auto_duty_pwm1_i(auto1), .auto_duty_pwm2_i(8'h00), .pwm1_duty_o(pwm1), .pwm2_duty_o(pwm2));
hot_source_model u_src (.clk_i(clk_i), .rstn_i(rstn_i), .hot_a_cmd_i(hot_a), .hot_b_cmd_i(1'b0),
	.meas_i(meas), .meas_go_i(go), .hot_a_o(vh_a), .hot_b_o(vh_b), .thr_o(thr), .thr_valid_o(tv));
// ----
// Shared tasks
// ----
task check(input [8*8-1:0] name, input [7:0] seen, input [7:0] exp);
begin
	checked = checked + 1;
	if (seen !== exp)
	begin
		errors = errors + 1;
		$display("mismatch %0s expected %h seen %h", name, exp, seen);
	end
end
endtask
task wr(input [7:0] a, input [7:0] d);
begin
	@(posedge clk_i);
	addr_i <= a;
	wdata_i <= d;
	wr_i <= 1'b1;
	@(posedge clk_i);
	wr_i <= 1'b0;
end
endtask
task rc(input [7:0] a, input [7:0] e);
begin
	@(posedge clk_i);
	addr_i <= a;
	rd_i <= 1'b1;
	@(posedge clk_i);
	rd_i <= 1'b0;
	#1 check("register", rdata_o, e);
end
endtask
task cyc(input integer n);
begin
	repeat (n) @(posedge clk_i);
	#1;
end
endtask
task wchg(input [7:0] old);
integer n;
begin
	n = 0;
	while (pwm1 === old && n < 30)
	begin
		cyc(1);
		n = n + 1;
	end
end
endtask
// ----
// Scenarios
// ----
task t_regs;
begin
	rc(8'h0A, 8'h00);
	rc(8'h0B, 8'h00);
	rc(8'h0E, 8'h00);
	wr(8'h0C, 8'h5A);
	wr(8'h0D, 8'hA5);
	rc(8'h0C, 8'h5A);
	rc(8'h0D, 8'hA5);
	wr(8'h0A, 8'h77);
	rc(8'h0A, 8'h00);
	rc(8'h30, 8'h00);
end
endtask
task t_spin;
begin
	@(posedge clk_i);
	full <= 2'b11;
	cyc(3);
	check("pwm2", pwm2, 8'hFF);
	@(posedge clk_i);
	full <= 2'b00;
	cyc(40);
	check("pwm1", pwm1, 8'h00);
	@(posedge clk_i);
	auto1 <= 8'h30;
	cyc(3);
	check("pwm1", pwm1, 8'hFF);
	cyc(40);
	check("pwm1", pwm1, 8'h30);
end
endtask
task t_hot;
begin
	wr(8'h51, 8'h01);
	@(posedge clk_i);
	hot_a <= 1'b1;
	wchg(8'h30);
	check("pwm1", pwm1, 8'h50);
	wchg(8'h50);
	check("pwm1", pwm1, 8'h60);
	check("pwm2", pwm2, 8'h00);
	cyc(200);
	check("pwm1", pwm1, 8'hFF);
	@(posedge clk_i);
	hot_a <= 1'b0;
	@(posedge clk_i);
	@(posedge clk_i);
	hot_a <= 1'b1;
	cyc(30);
	check("pwm1", pwm1, 8'hFF);
	@(posedge clk_i);
	hot_a <= 1'b0;
	wchg(8'hFF);
	check("pwm1", pwm1, 8'hF0);
	cyc(200);
	check("pwm1", pwm1, 8'h30);
	rc(8'h58, 8'h00);
end
endtask
task t_thr;
begin
	wr(8'h51, 8'h00);
	wr(8'h56, 8'h50);
	wr(8'h52, 8'h01);
	meas <= 8'h80;
	go <= 1'b1;
	@(posedge clk_i);
	go <= 1'b0;
	wchg(8'h30);
	check("pwm1", pwm1, 8'h50);
	check("pwm2", pwm2, 8'h00);
	@(posedge clk_i);
	meas <= 8'h50;
	go <= 1'b1;
	@(posedge clk_i);
	go <= 1'b0;
	cyc(200);
	check("pwm1", pwm1, 8'h30);
end
endtask
task t_ov;
begin
	wr(8'h52, 8'h00);
	wr(8'h53, 8'h01);
	wr(8'h0D, 8'h90);
	cyc(3);
	check("pwm1", pwm1, 8'h90);
	@(posedge clk_i);
	full <= 2'b01;
	cyc(3);
	check("pwm1", pwm1, 8'hFF);
	@(posedge clk_i);
	full <= 2'b00;
	wr(8'h53, 8'h00);
	cyc(3);
	check("pwm1", pwm1, 8'h30);
end
endtask
task give_verdict;
begin
	$display("checked %0d errors %0d", checked, errors);
	if (errors == 0 && checked > 0)
		$display("Run complete: PASS");
	else
		$display("Run complete: FAIL");
	$finish;
end
endtask
initial
begin
	#200000;
	errors = errors + 1;
	give_verdict;
end
initial
begin
	repeat (3) @(posedge clk_i);
	rstn_i <= 1'b1;
	t_regs;
	t_spin;
	t_hot;
	t_thr;
	t_ov;
	give_verdict;
end
endmodule
